// ===== design/svmon_defs.vh
// Constants for the supply voltage monitor control block
`ifndef SVMON_DEFS_VH
`define SVMON_DEFS_VH

// Register byte offsets
`define OFF_LEVEL_SEL    8'h00
`define OFF_CMP_CTRL     8'h04
`define OFF_MON1_STATUS  8'h08
`define OFF_MON2_STATUS  8'h0C
`define OFF_MON1_CTRL    8'h10
`define OFF_MON2_CTRL    8'h14
`define OFF_IRQ_STATUS   8'h18
`define OFF_IRQ_CLEAR    8'h1C
`define OFF_IRQ_ENABLE   8'h20
`define OFF_OPTION       8'h24

// Level-select register fields
`define LVL1_LSB         0
`define LVL1_MSB         3
`define LVL2_LSB         8
`define LVL2_MSB         9
// Highest legal monitor 1 level code (14 levels: 0..13)
`define LVL1_MAX         4'hD
// Comparator control: monitor 2 input select bit
`define CMP_INSEL_BIT    0
// Status register bits
`define ST_LEVEL_BIT     0
`define ST_CROSS_BIT     1
// Monitor control register bits
`define MC_RST_EN_BIT    0
`define MC_RESTART_BIT   1
`define MC_IRQ_EN_BIT    2
`define MC_NMI_BIT       3
`define MC_EDGE_LSB      4
`define MC_EDGE_MSB      5
// Edge codes
`define EDGE_BOTH        2'h0
`define EDGE_RISE        2'h1
`define EDGE_FALL        2'h2
// Option word field: monitor 0 level
`define OPT_LVL0_LSB     0
`define OPT_LVL0_MSB     1
// Event status bits
`define EV_MON1          0
`define EV_MON2          1
`define EV_MON0          2
`define EV_W             3
// Restart delay: 10 us at 200 MHz (5 ns)
`define RESTART_DELAY_NS 10000
`define CLK_PERIOD_NS    5
`define DELAY_W          16
`define DELAY_CYCLES     16'h07D0

`endif

// ===== design/sync2.v
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
`default_nettype none
module sync2 (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       d,
	output wire       q
);
	reg s1_ff;
	reg s2_ff;

	// First stage is read only by the second; both reset to the idle
	// level (above threshold) so reset release makes no false edge
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
		end else begin
			s1_ff <= d;
			s2_ff <= s1_ff;
		end
	end
	assign q = s2_ff;
endmodule // sync2
`default_nettype wire

// ===== design/restart_timer.v
// Reset hold and delayed restart for one voltage monitor
`timescale 1ns/10ps
`include "svmon_defs.vh"
`default_nettype none
module restart_timer (
	input  wire                 clk,
	input  wire                 rst_n,
	input  wire                 enable,
	input  wire                 restart_on_fall,
	input  wire                 above,
	input  wire                 fall,
	output reg                  reset_out
);
	reg [`DELAY_W-1:0] cnt_ff;
	reg                run_ff;

	// Reset asserts at the fall; release counts from rise or from fall
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_out <= 1'b0;
			run_ff    <= 1'b0;
			cnt_ff    <= {`DELAY_W{1'b0}};
		end else if (!enable) begin
			reset_out <= 1'b0;
			run_ff    <= 1'b0;
			cnt_ff    <= {`DELAY_W{1'b0}};
		end else if (fall) begin
			reset_out <= 1'b1;
			run_ff    <= restart_on_fall;
			cnt_ff    <= {`DELAY_W{1'b0}};
		end else if (reset_out) begin
			// Rise-restart mode waits for the level to recover first
			if (!run_ff && above && !restart_on_fall) begin
				run_ff <= 1'b1;
			end else if (run_ff) begin
				if (cnt_ff == `DELAY_CYCLES - 16'h0001) begin
					reset_out <= 1'b0;
					run_ff    <= 1'b0;
				end else begin
					cnt_ff <= cnt_ff + 16'h0001;
				end
			end
		end
	end
endmodule // restart_timer
`default_nettype wire

// ===== design/supply_voltage_monitor_ctrl.v
// Register, flag, reset, interrupt and event logic for three voltage monitors
// Notes on behaviour
// RULE1: Monitor 0 level is one of four, from the option word field.
// RULE2: Monitor 1 level is one of 14, from a 4-bit field.
// RULE3: Monitor 2 level is one of four, from a 2-bit field.
// RULE4: A control bit picks supply or external pin for monitor 2.
// RULE5: Monitors 1 and 2 show a live above/below level flag.
// RULE6: Monitors 1 and 2 set a sticky crossing flag on either crossing.
// RULE7: Monitor 0 resets while below; releases a fixed delay after rising.
// RULE8: Monitor 1 reset optional; restart delay counts from rise or from fall.
// RULE9: Monitor 2 has the same reset choice on its selected input.
// RULE10: Monitor 1 and 2 interrupts go out as non-maskable or maskable.
// RULE11: Monitor 1 interrupt on fall, rise or both, by edge setting.
// RULE12: Monitor 2 interrupt on fall, rise or both, by edge setting.
// RULE13: Monitor 1 crossings pulse an event-link output.
// RULE14: Monitor 2 crossings pulse an event-link output too.
// RULE15: Software clears a crossing flag by writing zero before the next.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/10ps
`include "svmon_defs.vh"
`default_nettype none
module supply_voltage_monitor_ctrl (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [1:0]  option_setting_word_1,
	input  wire        cmp0_above,
	input  wire        cmp1_above,
	input  wire        cmp2_supply_above,
	input  wire        cmp2_pin_above,
	output reg  [1:0]  threshold_0,
	output reg  [3:0]  threshold_1,
	output reg  [1:0]  threshold_2,
	output reg         monitor2_input_select,
	output reg         cpu_reset,
	output reg         nmi_out,
	output reg         irq_out,
	output reg         event_mon1,
	output reg         event_mon2
);
	localparam ST_IDLE   = 2'b01;
	localparam ST_ACCESS = 2'b10;

	////////////////////////////////////////////////////////////////////////////
	// Comparator synchronisers
	wire a0_s;
	wire a1_s;
	wire a2s_s;
	wire a2p_s;
	sync2 u_s0 (.clk(pclk), .rst_n(presetn), .d(cmp0_above), .q(a0_s));
	sync2 u_s1 (.clk(pclk), .rst_n(presetn), .d(cmp1_above), .q(a1_s));
	sync2 u_s2 (.clk(pclk), .rst_n(presetn), .d(cmp2_supply_above), .q(a2s_s));
	sync2 u_s3 (.clk(pclk), .rst_n(presetn), .d(cmp2_pin_above), .q(a2p_s));

	////////////////////////////////////////////////////////////////////////////
	// Registers
	reg [1:0]       state_ff;
	reg [3:0]       lvl1_ff;
	reg [1:0]       lvl2_ff;
	reg             insel_ff;
	reg [5:0]       mc1_ff;
	reg [5:0]       mc2_ff;
	reg             lvl1_flag_ff;
	reg             lvl2_flag_ff;
	reg             cross1_ff;
	reg             cross2_ff;
	reg [`EV_W-1:0] ev_st_ff;
	reg [`EV_W-1:0] ev_en_ff;
	reg             prev0_ff;
	reg             valid_ff;
	reg             opt_taken_ff;
	reg [1:0]       lvl0_ff;

	// Monitor 2 compares whichever input is selected
	wire a2_sel = insel_ff ? a2p_s : a2s_s; // RULE4
	wire rise1  = valid_ff && a1_s && !lvl1_flag_ff;
	wire fall1  = valid_ff && !a1_s && lvl1_flag_ff;
	wire rise2  = valid_ff && a2_sel && !lvl2_flag_ff;
	wire fall2  = valid_ff && !a2_sel && lvl2_flag_ff;
	wire x1     = rise1 | fall1;
	wire x2     = rise2 | fall2;
	wire fall0  = prev0_ff && !a0_s;

	// Edge filter for monitors 1 and 2
	wire [1:0] e1 = mc1_ff[`MC_EDGE_MSB:`MC_EDGE_LSB];
	wire [1:0] e2 = mc2_ff[`MC_EDGE_MSB:`MC_EDGE_LSB];
	wire hit1 = (rise1 && e1 != `EDGE_FALL) || (fall1 && e1 != `EDGE_RISE); // RULE11
	wire hit2 = (rise2 && e2 != `EDGE_FALL) || (fall2 && e2 != `EDGE_RISE); // RULE12

	wire wr = psel && penable && pwrite && (state_ff == ST_ACCESS);
	wire wr_lvl  = wr && paddr == `OFF_LEVEL_SEL;
	wire wr_st1  = wr && paddr == `OFF_MON1_STATUS;
	wire wr_st2  = wr && paddr == `OFF_MON2_STATUS;
	wire wr_clr  = wr && paddr == `OFF_IRQ_CLEAR;

	wire [`EV_W-1:0] ev_set = {fall0, hit2 & mc2_ff[`MC_IRQ_EN_BIT],
		hit1 & mc1_ff[`MC_IRQ_EN_BIT]};

	////////////////////////////////////////////////////////////////////////////
	// Reset timers
	wire rst0;
	wire rst1;
	wire rst2;
	restart_timer u_t0 (.clk(pclk), .rst_n(presetn), .enable(1'b1),
		.restart_on_fall(1'b0), .above(a0_s), .fall(fall0),
		.reset_out(rst0)); // RULE7
	restart_timer u_t1 (.clk(pclk), .rst_n(presetn), .enable(mc1_ff[`MC_RST_EN_BIT]),
		.restart_on_fall(mc1_ff[`MC_RESTART_BIT]), .above(a1_s), .fall(fall1),
		.reset_out(rst1)); // RULE8
	restart_timer u_t2 (.clk(pclk), .rst_n(presetn), .enable(mc2_ff[`MC_RST_EN_BIT]),
		.restart_on_fall(mc2_ff[`MC_RESTART_BIT]), .above(a2_sel), .fall(fall2),
		.reset_out(rst2)); // RULE9

	////////////////////////////////////////////////////////////////////////////
	// APB slave: no wait states, reads return from registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h00000000;
		end else begin
			case (state_ff)
			ST_IDLE: begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
				if (psel && !penable) begin
					state_ff <= ST_ACCESS;
					pready   <= 1'b1;
					pslverr  <= (paddr > `OFF_OPTION) || (paddr[1:0] != 2'h0);
					case (paddr)
					`OFF_LEVEL_SEL:   prdata <= {22'h0, lvl2_ff, 4'h0, lvl1_ff};
					`OFF_CMP_CTRL:    prdata <= {31'h0, insel_ff};
					`OFF_MON1_STATUS: prdata <= {30'h0, cross1_ff, lvl1_flag_ff};
					`OFF_MON2_STATUS: prdata <= {30'h0, cross2_ff, lvl2_flag_ff};
					`OFF_MON1_CTRL:   prdata <= {26'h0, mc1_ff};
					`OFF_MON2_CTRL:   prdata <= {26'h0, mc2_ff};
					`OFF_IRQ_STATUS:  prdata <= {29'h0, ev_st_ff};
					`OFF_IRQ_ENABLE:  prdata <= {29'h0, ev_en_ff};
					`OFF_OPTION:      prdata <= {30'h0, lvl0_ff};
					default:          prdata <= 32'h00000000;
					endcase
				end
			end
			ST_ACCESS: begin
				state_ff <= ST_IDLE;
				pready   <= 1'b0;
				pslverr  <= 1'b0;
			end
			default: state_ff <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl1_ff  <= 4'h0;
			lvl2_ff  <= 2'h0;
			insel_ff <= 1'b0;
			mc1_ff   <= 6'h00;
			mc2_ff   <= 6'h00;
			ev_en_ff <= 3'h0;
		end else if (wr) begin
			if (wr_lvl && pwdata[`LVL1_MSB:`LVL1_LSB] <= `LVL1_MAX)
				lvl1_ff <= pwdata[`LVL1_MSB:`LVL1_LSB]; // RULE2
			if (wr_lvl)
				lvl2_ff <= pwdata[`LVL2_MSB:`LVL2_LSB]; // RULE3
			if (paddr == `OFF_CMP_CTRL)
				insel_ff <= pwdata[`CMP_INSEL_BIT]; // RULE4
			if (paddr == `OFF_MON1_CTRL)
				mc1_ff <= pwdata[5:0];
			if (paddr == `OFF_MON2_CTRL)
				mc2_ff <= pwdata[5:0];
			if (paddr == `OFF_IRQ_ENABLE)
				ev_en_ff <= pwdata[`EV_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Option word sampled once after reset release
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opt_taken_ff <= 1'b0;
			lvl0_ff      <= 2'h0;
		end else if (!opt_taken_ff) begin
			opt_taken_ff <= 1'b1;
			lvl0_ff <= option_setting_word_1[`OPT_LVL0_MSB:`OPT_LVL0_LSB]; // RULE1
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Level and crossing flags; a crossing beats a same-cycle clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valid_ff     <= 1'b0;
			lvl1_flag_ff <= 1'b1;
			lvl2_flag_ff <= 1'b1;
			cross1_ff    <= 1'b0;
			cross2_ff    <= 1'b0;
			prev0_ff     <= 1'b1;
			ev_st_ff     <= 3'h0;
		end else begin
			valid_ff     <= 1'b1;
			prev0_ff     <= a0_s;
			lvl1_flag_ff <= a1_s;   // RULE5
			lvl2_flag_ff <= a2_sel; // RULE5
			if (x1)
				cross1_ff <= 1'b1; // RULE6
			else if (wr_st1 && !pwdata[`ST_CROSS_BIT])
				cross1_ff <= 1'b0; // RULE15
			if (x2)
				cross2_ff <= 1'b1; // RULE6
			else if (wr_st2 && !pwdata[`ST_CROSS_BIT])
				cross2_ff <= 1'b0; // RULE15
			// Write-one-to-clear, new events win
			ev_st_ff <= (ev_st_ff & ~(wr_clr ? pwdata[`EV_W-1:0] : 3'h0)) | ev_set;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			threshold_0           <= 2'h0;
			threshold_1           <= 4'h0;
			threshold_2           <= 2'h0;
			monitor2_input_select <= 1'b0;
			cpu_reset             <= 1'b0;
			nmi_out               <= 1'b0;
			irq_out               <= 1'b0;
			event_mon1            <= 1'b0;
			event_mon2            <= 1'b0;
		end else begin
			threshold_0           <= lvl0_ff;
			threshold_1           <= lvl1_ff;
			threshold_2           <= lvl2_ff;
			monitor2_input_select <= insel_ff;
			cpu_reset             <= rst0 | rst1 | rst2;
			// Non-maskable path bypasses the enable register
			nmi_out <= (ev_st_ff[`EV_MON1] & mc1_ff[`MC_NMI_BIT]) |
				(ev_st_ff[`EV_MON2] & mc2_ff[`MC_NMI_BIT]); // RULE10
			irq_out <= |(ev_st_ff & ev_en_ff &
				{1'b1, ~mc2_ff[`MC_NMI_BIT], ~mc1_ff[`MC_NMI_BIT]}); // RULE10
			event_mon1 <= x1; // RULE13
			event_mon2 <= x2; // RULE14
		end
	end
endmodule // supply_voltage_monitor_ctrl
`default_nettype wire

// ===== verif/svmon_model.sv
// Comparator model for the three supply voltage monitors
`timescale 1ns/10ps
`default_nettype none
module svmon_model (
	input  wire logic [3:0] vcc,
	input  wire logic [3:0] pin,
	input  wire logic [1:0] threshold_0,
	input  wire logic [3:0] threshold_1,
	input  wire logic [1:0] threshold_2,
	output logic            cmp0_above,
	output logic            cmp1_above,
	output logic            cmp2_supply_above,
	output logic            cmp2_pin_above
);
	// Ideal comparators: no hysteresis, so every step across a threshold is a crossing
	always_comb begin
		cmp0_above = vcc > {2'h0, threshold_0};
		cmp1_above = vcc > threshold_1;
		cmp2_supply_above = vcc > {2'h0, threshold_2};
		cmp2_pin_above = pin > {2'h0, threshold_2};
	end
endmodule // svmon_model
`default_nettype wire

// ===== verif/svmon_sva.sv
// Port assertions for the supply voltage monitor control block
`timescale 1ns/10ps
`include "svmon_defs.vh"
`default_nettype none
module svmon_sva (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pwrite,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic [1:0] option_setting_word_1,
	input wire logic       cmp0_above,
	input wire logic       cmp1_above,
	input wire logic       cmp2_supply_above,
	input wire logic       cmp2_pin_above,
	input wire logic [1:0] threshold_0,
	input wire logic [3:0] threshold_1,
	input wire logic       monitor2_input_select,
	input wire logic       cpu_reset,
	input wire logic       event_mon1,
	input wire logic       event_mon2
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [11:0] up_ff;
	wire sel2 = monitor2_input_select ? cmp2_pin_above : cmp2_supply_above;
	wire wr4 = psel && penable && pwrite && paddr == `OFF_CMP_CTRL;
	// Cycles since the supply was last low; saturates so old dips age out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up_ff <= 12'hFFF;
		else if (!cmp0_above)
			up_ff <= 12'h000;
		else if (up_ff != 12'hFFF)
			up_ff <= up_ff + 12'h001;
	end
	answer_a: assert property (psel && !penable |=> pready) else $error("no answer");
	lvl0_a: assert property ($rose(presetn) |-> ##[1:3] threshold_0 == option_setting_word_1)
		else $error("level 0 code");
	lvl1_a: assert property (threshold_1 <= `LVL1_MAX) else $error("level 1 code");
	insel_a: assert property ($changed(monitor2_input_select) |-> $past(wr4) || $past(wr4, 2))
		else $error("select moved");
	cross1_a: assert property ($changed(cmp1_above) |-> ##[1:6] event_mon1)
		else $error("no event 1");
	cross2_a: assert property ($changed(sel2) && $stable(monitor2_input_select) |->
		##[1:6] event_mon2) else $error("no event 2");
	mon0_a: assert property ($fell(cmp0_above) |-> ##[1:6] cpu_reset) else $error("no reset");
	early_a: assert property ($fell(cpu_reset) |-> up_ff >= 12'h7D0)
		else $error("early release");
	cover property (event_mon1);
	cover property (event_mon2);
	cover property ($fell(cpu_reset));
endmodule // svmon_sva
//////////////////////////////////////////////////
bind supply_voltage_monitor_ctrl svmon_sva u_svmon_sva (.*);
`default_nettype wire

// ===== verif/supply_voltage_monitor_ctrl_test.sv
// Self-checking bench for the supply voltage monitor control block
`timescale 1ns/10ps
`include "svmon_defs.vh"
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; \
$display("mismatch %s exp %h got %h", n, e, s); end end
module supply_voltage_monitor_ctrl_test;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [1:0]  option_setting_word_1 = 2'h0;
	logic [3:0]  vcc = 4'hF;
	logic [3:0]  pin = 4'hF;
	logic [31:0] prdata;
	logic [3:0]  threshold_1, lo, lvl;
	logic [1:0]  threshold_0, threshold_2;
	logic        pready, pslverr, cmp0_above, cmp1_above, cmp2_supply_above, cmp2_pin_above;
	logic        monitor2_input_select, cpu_reset, nmi_out, irq_out, event_mon1, event_mon2;
	logic        nmi, hit;
	logic [32:0] ev;
	logic [32:0] q[$];
	int          n_fail = 0;
	int          n_tests = 0;
	int          k, j, m, e, n, b;
	supply_voltage_monitor_ctrl u_supply_voltage_monitor_ctrl (.*);
	svmon_model u_svmon_model (.*);
	always #2.5 pclk = ~pclk;
	//////////////////////////////////////////////////
	task automatic end_of_test();
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One transfer; a read leaves {error, data} behind for the watcher
	task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] d);
		int t;
		if (!w)
			q.push_back(d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d[31:0];
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 16);
		if (t >= 16) begin
			n_fail++;
			end_of_test();
		end
	endtask
	task automatic idle(input int c);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (c) @(posedge pclk);
	endtask
	// Cycles until the CPU reset drops; bounded so a stuck reset ends the run
	task automatic rel_time(output int c);
		c = 0;
		while (cpu_reset !== 1'b0 && c < 2100) begin
			@(posedge pclk);
			c++;
		end
		if (c >= 2100) begin
			n_fail++;
			end_of_test();
		end
	endtask
	// Oldest read expectation against each read answer
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite && q.size() > 0) begin
			ev = q.pop_front();
			if (ev[32])
				`CHK("pslverr", 1'b1, pslverr)
			else
				`CHK("prdata", ev, {pslverr, prdata})
		end
	initial begin
		void'($urandom(32'hC7E0));
		option_setting_word_1 = 2'($urandom % 4);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		idle(4);
		`CHK("threshold_0", option_setting_word_1, threshold_0)
		apb(1, `OFF_OPTION, 33'h3);
		apb(0, `OFF_OPTION, {31'h0, option_setting_word_1});
		apb(0, 8'h28, {1'b1, 32'h0});
		apb(0, 8'h02, {1'b1, 32'h0});
		lvl = 4'h0;
		// Every level code; codes past thirteen must leave the field alone
		for (k = 0; k < 16; k++) begin
			if (k <= 13)
				lvl = k[3:0];
			apb(1, `OFF_LEVEL_SEL, {23'h0, k[1:0], 4'h0, k[3:0]});
			apb(0, `OFF_LEVEL_SEL, {23'h0, k[1:0], 4'h0, lvl});
			idle(2);
			`CHK("threshold_1", lvl, threshold_1)
			`CHK("threshold_2", k[1:0], threshold_2)
		end
		apb(1, `OFF_CMP_CTRL, 33'h1);
		apb(0, `OFF_CMP_CTRL, 33'h1);
		apb(1, `OFF_IRQ_ENABLE, 33'h3);
		// Both monitors, every edge code, maskable and non-maskable
		for (k = 0; k < 6; k++) begin
			m = k / 3;
			e = k % 3;
			nmi = e == 0;
			apb(1, m ? `OFF_MON2_CTRL : `OFF_MON1_CTRL, {27'h0, e[1:0], nmi, 3'h4});
			for (j = 0; j < 2; j++) begin
				hit = j ? e != 2 : e != 1;
				lo = 4'h4 + 4'($urandom % 9);
				if (m)
					pin <= j ? 4'hF : 4'h0;
				else
					vcc <= j ? 4'hF : lo;
				idle(8);
				`CHK("irq_out", hit && !nmi, irq_out)
				`CHK("nmi_out", hit && nmi, nmi_out)
				apb(0, `OFF_IRQ_STATUS, {32'h0, hit} << m);
				apb(0, m ? `OFF_MON2_STATUS : `OFF_MON1_STATUS, {31'h1, j[0]});
				apb(1, `OFF_IRQ_CLEAR, 33'h3);
				apb(1, m ? `OFF_MON2_STATUS : `OFF_MON1_STATUS, 33'h0);
				apb(0, m ? `OFF_MON2_STATUS : `OFF_MON1_STATUS, {32'h0, j[0]});
				idle(2);
				`CHK("irq_clear", 1'b0, irq_out || nmi_out)
			end
		end
		apb(1, `OFF_MON2_CTRL, 33'h0);
		// Monitor 0, monitor 1 and 2 restart on rise, monitor 1 restart on fall
		for (k = 0; k < 4; k++) begin
			apb(1, k == 2 ? `OFF_MON2_CTRL : `OFF_MON1_CTRL, k == 3 ? 33'h3 : {32'h0, k != 0});
			idle(1);
			if (k == 2)
				pin <= 4'h0;
			else
				vcc <= k ? lo : 4'h0;
			idle(8);
			`CHK("cpu_reset", 1'b1, cpu_reset)
			if (k == 2)
				pin <= 4'hF;
			else if (k < 3)
				vcc <= 4'hF;
			b = k == 3 ? 12'h7C8 : 12'h7D0;
			rel_time(n);
			`CHK("restart", 1'b1, n >= b && n <= b + 12'h00A)
			vcc <= 4'hF;
			idle(8);
		end
		end_of_test();
	end
endmodule // supply_voltage_monitor_ctrl_test
`default_nettype wire
